// ===== pkg/par_pkg.sv
// constants and types for the physical-address routing decoder
package par_pkg;
  localparam int unsigned PA_W          = 52;
  localparam int unsigned REG_W         = 64;
  // register indices on the register port
  localparam logic [2:0] IDX_BASE0      = 3'h0;
  localparam logic [2:0] IDX_MASK0      = 3'h1;
  localparam logic [2:0] IDX_BASE1      = 3'h2;
  localparam logic [2:0] IDX_MASK1      = 3'h3;
  localparam logic [2:0] IDX_LOW_BND    = 3'h4;
  localparam logic [2:0] IDX_HIGH_BND   = 3'h5;
  localparam logic [2:0] IDX_SYSTEM_CONFIG_REG     = 3'h6;
  localparam logic [2:0] IDX_FEATURE    = 3'h7;
  // field positions
  localparam int unsigned WR_MEM_BIT    = 3;
  localparam int unsigned RD_MEM_BIT    = 4;
  localparam int unsigned VALID_BIT     = 11;
  localparam int unsigned RANGE_LSB     = 12;
  localparam int unsigned RANGE_MSB     = 51;
  localparam int unsigned BND_LSB       = 23;
  localparam int unsigned BND_MSB       = 51;
  localparam int unsigned LOW_EN_BIT    = 20;
  localparam int unsigned HIGH_EN_BIT   = 21;
  localparam int unsigned ENC_EN_BIT    = 23;
  localparam int unsigned FEAT_ENC_BIT  = 0;
  // 4-Gbyte line as a page number at bit 23 granularity
  localparam logic [28:0] FOUR_GB_BND   = 29'h0000_0200;
  // reset values
  localparam logic [63:0] REG_RST       = 64'h0000_0000_0000_0000;
  // implementation figures: encryption bit position and reduced address size
  localparam logic [5:0]  ENC_BIT_POS   = 6'h2F;
  localparam logic [5:0]  PA_REDUCTION  = 6'h05;
  // memory type codes
  localparam logic [2:0]  MT_UC         = 3'h0;
  localparam logic [2:0]  MT_WC         = 3'h1;
  localparam logic [2:0]  MT_WT         = 3'h4;
  localparam logic [2:0]  MT_WP         = 3'h5;
  localparam logic [2:0]  MT_WB         = 3'h6;
endpackage

// ===== src/par_decoder.sv
// physical-address routing decoder with range pairs, boundaries and encryption checks
// How it works
// - two I/O range pairs, base and mask, read and writable by software.
// - base bit 3 sends writes in a matching range to memory, else I/O.
// - base bit 4 sends reads in a matching range to memory, else I/O.
// - base field bits 51:12 is the upper address; low 12 bits zero.
// - mask bit 11 enables the pair; a clear pair is ignored.
// - mask field bits 51:12, low 12 bits treated as zero.
// - range routing bits combine with memory type via the permitted table.
// - UC/WC/WT/WP need both bits clear, WB both set; others flagged reserved.
// - low boundary on: below it memory, up to 4 GB I/O.
// - high boundary on: 4 GB up to it memory, above it I/O.
// - boundaries keep only bits 51:23; other bits ignored, read zero.
// - config bit 20 enables low boundary, bit 21 high boundary.
// - disabled boundaries send their accesses to I/O.
// - encrypted pages marked for the cipher on DRAM access; key never visible.
// - feature register bit 0 reports encryption, plus bit position and reduction.
// - encryption acts only while config bit 23 is set.
// - encryption attribute honoured only with address extension and paging on.
// - attribute 1 stores encrypted, 0 plain, for every page size.
// - table fetch under an encrypted entry is an encrypted fetch.
// - reduced size: nonzero reserved bits fault; checks drop the encryption bit.
// - encrypted access to I/O raises machine check.
`timescale 1ns/1ps
module par_decoder
  import par_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  // register port
  input  wire logic                  reg_wr,
  input  wire logic [2:0]            reg_idx,
  input  wire logic [par_pkg::REG_W-1:0] reg_wdata,
  output logic [par_pkg::REG_W-1:0]  reg_rdata,
  // access request from translation path
  input  wire logic                  acc_valid,
  input  wire logic                  acc_write,
  input  wire logic                  acc_table_fetch,
  input  wire logic                  acc_parent_enc,
  input  wire logic [par_pkg::PA_W-1:0] acc_addr,
  input  wire logic [2:0]            acc_mem_type,
  input  wire logic                  addr_extension_on,
  input  wire logic                  paging_on,
  // routing answer
  output logic                       rte_valid,
  output logic                       rte_to_memory,
  output logic                       rte_encrypted,
  output logic                       rte_page_fault,
  output logic                       rte_machine_check,
  output logic                       rte_reserved_combo
);
  import par_pkg::*;

  // keep masks for the implemented register fields
  localparam logic [63:0] BASE_KEEP = 64'h000F_FFFF_FFFF_F018;
  localparam logic [63:0] MASK_KEEP = 64'h000F_FFFF_FFFF_F800;
  // lowest reserved bit once the address shrinks by the reduction
  localparam logic [5:0]  RSVD_LSB  = 6'd48 - PA_REDUCTION;

  // range pair storage
  logic [63:0] base_q [2];
  logic [63:0] mask_q [2];

  // boundary storage, bits 51:23 only
  logic [28:0] low_bnd_q;
  logic [28:0] high_bnd_q;

  // configuration enables
  logic        low_en_q;
  logic        high_en_q;
  logic        enc_en_q;

  // range pair writes; unimplemented bits drop here so reads see zero
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      base_q[0] <= REG_RST;
      base_q[1] <= REG_RST;
      mask_q[0] <= REG_RST;
      mask_q[1] <= REG_RST;
    end
    else if (reg_wr)
    begin
      if (reg_idx == IDX_BASE0)
        base_q[0] <= reg_wdata & BASE_KEEP;
      if (reg_idx == IDX_MASK0)
        mask_q[0] <= reg_wdata & MASK_KEEP;
      if (reg_idx == IDX_BASE1)
        base_q[1] <= reg_wdata & BASE_KEEP;
      if (reg_idx == IDX_MASK1)
        mask_q[1] <= reg_wdata & MASK_KEEP;
    end
  end

  // boundary writes; the 8-Mbyte alignment is the field itself
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_bnd_q  <= '0;
      high_bnd_q <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_idx == IDX_LOW_BND)
        low_bnd_q <= reg_wdata[BND_MSB:BND_LSB];
      if (reg_idx == IDX_HIGH_BND)
        high_bnd_q <= reg_wdata[BND_MSB:BND_LSB];
    end
  end

  // configuration writes; the feature word at index 7 is read only
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_en_q  <= 1'b0;
      high_en_q <= 1'b0;
      enc_en_q  <= 1'b0;
    end
    else if (reg_wr && reg_idx == IDX_SYSTEM_CONFIG_REG)
    begin
      low_en_q  <= reg_wdata[LOW_EN_BIT];
      high_en_q <= reg_wdata[HIGH_EN_BIT];
      enc_en_q  <= reg_wdata[ENC_EN_BIT];
    end
  end

  // read mux, registered so the output comes from a flip-flop
  logic [63:0] rd_d;
  always_comb
  begin
    rd_d = '0;
    unique case (reg_idx)
      IDX_BASE0:
      begin
        rd_d = base_q[0];
      end
      IDX_MASK0:
      begin
        rd_d = mask_q[0];
      end
      IDX_BASE1:
      begin
        rd_d = base_q[1];
      end
      IDX_MASK1:
      begin
        rd_d = mask_q[1];
      end
      IDX_LOW_BND:
      begin
        rd_d[BND_MSB:BND_LSB] = low_bnd_q;
      end
      IDX_HIGH_BND:
      begin
        rd_d[BND_MSB:BND_LSB] = high_bnd_q;
      end
      IDX_SYSTEM_CONFIG_REG:
      begin
        rd_d[LOW_EN_BIT]  = low_en_q;
        rd_d[HIGH_EN_BIT] = high_en_q;
        rd_d[ENC_EN_BIT]  = enc_en_q;
      end
      IDX_FEATURE:
      begin
        rd_d[FEAT_ENC_BIT] = 1'b1;
        rd_d[37:32]        = ENC_BIT_POS;
        rd_d[43:38]        = PA_REDUCTION;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= '0;
    else
      reg_rdata <= rd_d;
  end

  // encryption attribute and effective address
  logic        enc_active;
  logic        c_bit;
  logic [51:0] eff_addr;
  logic [51:0] rsvd_mask;
  logic        rsvd_hit;

  // attribute counts only when enabled and in a paged extended mode
  always_comb
  begin
    enc_active = enc_en_q && addr_extension_on && paging_on;
    // a table fetch inherits the attribute of the entry that pointed at it
    c_bit      = enc_active &&
                 (acc_table_fetch ? acc_parent_enc : acc_addr[ENC_BIT_POS]);
  end

  // reserved bits sit above the reduced size; the c-bit is not one of them
  always_comb
  begin
    rsvd_mask              = ~((52'h1 << RSVD_LSB) - 52'h1);
    rsvd_mask[ENC_BIT_POS] = 1'b0;
    rsvd_hit               = enc_active && |(acc_addr & rsvd_mask);
  end

  // range checks drop the c-bit while config bit 23 is set, even outside the paged modes
  always_comb
  begin
    eff_addr = acc_addr;
    if (enc_en_q)
      eff_addr[ENC_BIT_POS] = 1'b0;
  end

  // range pair match on bits 51:12
  wire logic [1:0] pair_hit;
  logic            rng_hit;
  logic            rng_rd;
  logic            rng_wr;

  // one comparator per pair; a pair with its valid bit clear never hits
  for (genvar g = 0; g < 2; g++)
  begin : g_pair
    assign pair_hit[g] = mask_q[g][VALID_BIT] &&
      ((eff_addr[RANGE_MSB:RANGE_LSB] & mask_q[g][RANGE_MSB:RANGE_LSB]) ==
       (base_q[g][RANGE_MSB:RANGE_LSB] & mask_q[g][RANGE_MSB:RANGE_LSB]));
  end

  // overlap is left to software; pair 0 simply has priority here
  always_comb
  begin
    rng_hit = |pair_hit;
    rng_rd  = pair_hit[0] ? base_q[0][RD_MEM_BIT] : base_q[1][RD_MEM_BIT];
    rng_wr  = pair_hit[0] ? base_q[0][WR_MEM_BIT] : base_q[1][WR_MEM_BIT];
  end

  // boundary decode; disabled boundaries fall through to I/O
  logic       below_4g;
  logic       bnd_mem;
  logic       to_mem;
  logic       combo_bad;

  // the 4-Gbyte line splits the two boundary registers
  always_comb
  begin
    below_4g = (eff_addr[51:32] == 20'h0_0000);
    if (below_4g)
      bnd_mem = low_en_q && (eff_addr[51:23] < low_bnd_q);
    else
      bnd_mem = high_en_q && (eff_addr[51:23] >= FOUR_GB_BND) &&
                (eff_addr[51:23] < high_bnd_q);
  end

  // a matching range pair overrides the boundaries
  always_comb
  begin
    to_mem = rng_hit ? (acc_write ? rng_wr : rng_rd) : bnd_mem;
  end

  // permitted pairings of routing bits and memory type
  always_comb
  begin
    combo_bad = 1'b0;
    if (rng_hit)
    begin
      unique case (acc_mem_type)
        MT_UC, MT_WC, MT_WT, MT_WP: combo_bad = rng_rd | rng_wr;
        MT_WB:                      combo_bad = ~(rng_rd & rng_wr);
        default:                    combo_bad = 1'b1;
      endcase
    end
  end

  // routing answer, one cycle after the request
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rte_valid          <= 1'b0;
      rte_to_memory      <= 1'b0;
      rte_reserved_combo <= 1'b0;
    end
    else
    begin
      rte_valid          <= acc_valid;
      rte_to_memory      <= acc_valid && to_mem;
      rte_reserved_combo <= acc_valid && combo_bad;
    end
  end

  // cipher flags; a reserved-bit fault wins over both cipher outcomes
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rte_encrypted     <= 1'b0;
      rte_page_fault    <= 1'b0;
      rte_machine_check <= 1'b0;
    end
    else
    begin
      rte_encrypted     <= acc_valid && c_bit && to_mem && !rsvd_hit;
      rte_page_fault    <= acc_valid && rsvd_hit;
      rte_machine_check <= acc_valid && c_bit && !to_mem && !rsvd_hit;
    end
  end
endmodule

// ===== tb/par_decoder_asserts.sv
// assertion checker for the address routing decoder
`timescale 1ns/1ps
module par_chk
  import par_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        reg_wr,
  input wire logic [2:0]  reg_idx,
  input wire logic [63:0] reg_wdata,
  input wire logic [63:0] reg_rdata,
  input wire logic        acc_valid,
  input wire logic [51:0] acc_addr,
  input wire logic        addr_extension_on,
  input wire logic        paging_on,
  input wire logic        rte_valid,
  input wire logic        rte_to_memory,
  input wire logic        rte_encrypted,
  input wire logic        rte_page_fault,
  input wire logic        rte_machine_check
);
  logic [2:0] en_q;  // config enables 23,21,20
  logic [1:0] vld_q; // range pair valid bits
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // shadow only the bits that gate the checks below
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_q  <= 3'h0;
      vld_q <= 2'h0;
    end
    else if (reg_wr)
    begin
      if (reg_idx == IDX_SYSTEM_CONFIG_REG) en_q <= {reg_wdata[23], reg_wdata[21:20]};
      if (reg_idx == IDX_MASK0) vld_q[0] <= reg_wdata[11];
      if (reg_idx == IDX_MASK1) vld_q[1] <= reg_wdata[11];
    end
  end
  property p_lat; acc_valid |=> rte_valid; endproperty
  a_lat: assert property (p_lat) else $error("no answer");
  property p_mc; rte_machine_check |-> rte_valid && !rte_to_memory; endproperty
  a_mc: assert property (p_mc) else $error("check on memory");
  property p_enc; rte_encrypted |-> rte_to_memory; endproperty
  a_enc: assert property (p_enc) else $error("cipher on io");
  property p_pf; rte_page_fault |-> !rte_encrypted && !rte_machine_check; endproperty
  a_pf: assert property (p_pf) else $error("fault not exclusive");
  property p_mode; acc_valid && !(addr_extension_on && paging_on) |=> !rte_encrypted; endproperty
  a_mode: assert property (p_mode) else $error("cipher off mode");
  property p_off; acc_valid && !en_q[2] |=> !(rte_encrypted || rte_page_fault); endproperty
  a_off: assert property (p_off) else $error("cipher disabled");
  property p_dflt; acc_valid && en_q[1:0] == 2'h0 && vld_q == 2'h0 |=> !rte_to_memory; endproperty
  a_dflt: assert property (p_dflt) else $error("default not io");
  property p_feat; reg_idx == IDX_FEATURE |=> reg_rdata == 64'h0000_016F_0000_0001; endproperty
  a_feat: assert property (p_feat) else $error("feature word");
endmodule
bind par_decoder par_chk chk_u (.core_clk, .rst_b, .reg_wr, .reg_idx, .reg_wdata, .reg_rdata,
  .acc_valid, .acc_addr, .addr_extension_on, .paging_on, .rte_valid, .rte_to_memory,
  .rte_encrypted, .rte_page_fault, .rte_machine_check);

// ===== tb/par_xlate_model.sv
// translation-path model issuing random physical accesses
`timescale 1ns/1ps
module par_xlate_model
  import par_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  rst_b,
  input  wire logic  run,
  output logic        acc_valid,
  output logic        acc_write,
  output logic        acc_table_fetch,
  output logic        acc_parent_enc,
  output logic [51:0] acc_addr,
  output logic [2:0]  acc_mem_type,
  output logic        addr_extension_on,
  output logic        paging_on
);
  integer      seed = 56;
  logic [31:0] r;
  // one draw per edge, so requests may land back to back
  always @(posedge core_clk)
  begin
    r = $random(seed);
    acc_valid <= rst_b & run & r[0];
    acc_write <= r[1];
    acc_table_fetch <= r[2] & r[3];
    acc_parent_enc <= r[4];
    acc_mem_type <= r[7] ? MT_WB : {r[6], 1'b0, r[5]}; // listed types only
    addr_extension_on <= r[8] | r[9];
    paging_on <= r[10] | r[11];
    // top: attribute bit, a reserved bit or clear; 34 low bits random
    acc_addr <= {r[12] ? 9'h010 : {r[13] & r[14], 8'h00}, 9'h000, r[16:15], $random(seed)};
  end
endmodule

// ===== tb/par_decoder_test.sv
// self-checking bench for the address routing decoder
`timescale 1ns/1ps
module par_decoder_test
  import par_pkg::*;
;
  localparam logic [63:0] M = 64'h000F_FFFF_C000_0000;
  localparam logic [63:0] U [8] = '{64'h1_C000_0018, 64'h800, 64'h1_C000_0018, 64'h800,
    64'h3_FF80_0000, 64'h3_FF80_0000, 64'hB0_0000, '1};
  localparam logic [63:0] F [8] = '{64'h0, M, 64'h2_0000_0000, M, 64'h0, 64'h0, 64'h0, 64'h0};
  localparam logic [63:0] K [8] = '{64'hF_FFFF_FFFF_F018, 64'hF_FFFF_FFFF_F800,
    64'hF_FFFF_FFFF_F018, 64'hF_FFFF_FFFF_F800, 64'hF_FFFF_FF80_0000,
    64'hF_FFFF_FF80_0000, 64'hB0_0000, 64'h0000_016F_0000_0001};
  logic        core_clk = 1'b0;
  logic        rst_b, reg_wr, run, on, pf, at, mem, rc;
  logic [2:0]  reg_idx, acc_mem_type;
  logic [63:0] reg_wdata, reg_rdata, d;
  logic [63:0] rg [8];
  logic        acc_valid, acc_write, acc_table_fetch, acc_parent_enc, addr_extension_on;
  logic        paging_on, rte_valid, rte_to_memory, rte_encrypted, rte_page_fault;
  logic        rte_machine_check, rte_reserved_combo;
  logic [51:0] acc_addr, a;
  logic [4:0]  e, got;
  logic [4:0]  q [$];
  int          err_count = 0;
  int          checked = 0;
  int          n, k, i;
  assign got = {rte_to_memory, rte_encrypted, rte_page_fault, rte_machine_check,
    rte_reserved_combo};
  par_decoder dut_u (.core_clk, .rst_b, .reg_wr, .reg_idx, .reg_wdata, .reg_rdata, .acc_valid,
    .acc_write, .acc_table_fetch, .acc_parent_enc, .acc_addr, .acc_mem_type, .addr_extension_on,
    .paging_on, .rte_valid, .rte_to_memory, .rte_encrypted, .rte_page_fault, .rte_machine_check,
    .rte_reserved_combo);
  par_xlate_model xm_u (.core_clk, .rst_b, .run, .acc_valid, .acc_write, .acc_table_fetch,
    .acc_parent_enc, .acc_addr, .acc_mem_type, .addr_extension_on, .paging_on);
  // 50 MHz core clock
  always #10 core_clk = ~core_clk;
  task automatic fail(input logic [63:0] g, input logic [63:0] x);
    err_count++;
    $display("FAIL %0t got %h exp %h", $time, g, x);
  endtask
  task automatic chk_reg(input logic [63:0] g, input logic [63:0] x);
    checked++;
    if (g !== x) fail(g, x);
  endtask
  // routing is a don't-care once the fault wins
  task automatic chk_rte(input logic [4:0] g, input logic [4:0] x);
    checked++;
    if ((g & (x[2] ? 5'h0E : 5'h1F)) !== (x & (x[2] ? 5'h0E : 5'h1F))) fail(g, x);
  endtask
  task automatic wr(input logic [2:0] ix, input logic [63:0] dv);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_idx <= ix;
    reg_wdata <= dv;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] ix);
    @(posedge core_clk);
    reg_idx <= ix;
    repeat (2) @(posedge core_clk);
    #1 chk_reg(reg_rdata, rg[ix]);
  endtask
  task automatic test_done;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // reference decode: queued at the request edge, compared at the answer edge
  always @(posedge core_clk)
  begin
    if (rte_valid)
    begin
      e = q.size() ? q.pop_front() : 5'hx;
      chk_rte(got, e);
    end
    if (acc_valid)
    begin
      a = acc_addr;
      a[47] = a[47] & !rg[6][23]; // attribute is no address bit
      on = rg[6][23] & addr_extension_on & paging_on;
      pf = on && (acc_addr[51:43] & 9'h1EF) != 9'h0;
      at = on & !pf & (acc_table_fetch ? acc_parent_enc : acc_addr[47]);
      mem = (a[51:32] == 20'h0) ? rg[6][20] && a[51:23] < rg[4][51:23]
        : rg[6][21] && a[51:23] < rg[5][51:23];
      rc = 1'b0;
      for (i = 1; i >= 0; i--)
        if (rg[2*i+1][11] && ((a[51:12] ^ rg[2*i][51:12]) & rg[2*i+1][51:12]) == 40'h0)
        begin
          mem = acc_write ? rg[2*i][3] : rg[2*i][4];
          rc = (acc_mem_type == MT_WB) ? rg[2*i][4:3] != 2'b11 : rg[2*i][4:3] != 2'b00;
        end
      q.push_back({mem, at & mem, pf, at & !mem, rc});
    end
  end
  // rounds: program all registers, read back, then stream accesses
  initial
  begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_idx = 3'h0;
    reg_wdata = 64'h0;
    run = 1'b0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    for (n = 0; n < 8; n++)
    begin
      for (k = 0; k < 8; k++)
      begin
        d = (n == 0) ? 64'h0 : {$random(xm_u.seed), $random(xm_u.seed)} & U[k];
        d = d | F[k] | 64'hFFF0_0000_0000_0407; // disjoint bases
        wr(k[2:0], d);
        rg[k] = (k == 7) ? K[7] : d & K[k];
      end
      for (k = 0; k < 8; k++) rd(k[2:0]);
      run <= 1'b1;
      repeat (300) @(posedge core_clk);
      run <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk_reg(64'(q.size()), 64'h0);
      $display("round %0d done", n);
    end
    test_done;
  end
endmodule
